/* hdl/gpe_engine.sv */
// The AXI4-Lite register port and the register offsets were left to the implementer.
`timescale 1ns/1ns
module gpe_engine
	import gpe_pkg::*;
#(
	parameter int                  CYCLES_PER_MS = CLK_HZ / MS_PER_S,
	parameter logic [15:0]         HW_VERSION    = 16'h0100, // Arbitrary value.
	parameter logic [15:0]         FW_VERSION    = 16'h0100, // Arbitrary value.
	parameter logic [8*NAME_LEN-1:0] FW_NAME     = {"FIRMWARE.BIN", 48'h0}
)(
	input  wire logic              clk,
	input  wire logic              rst,
	input  wire logic [ADDR_W-1:0] awaddr,
	input  wire logic              awvalid,
	output logic                   awready,
	input  wire logic [31:0]       wdata,
	input  wire logic [3:0]        wstrb,
	input  wire logic              wvalid,
	output logic                   wready,
	output logic [1:0]             bresp,
	output logic                   bvalid,
	input  wire logic              bready,
	input  wire logic [ADDR_W-1:0] araddr,
	input  wire logic              arvalid,
	output logic                   arready,
	output logic [31:0]            rdata,
	output logic [1:0]             rresp,
	output logic                   rvalid,
	input  wire logic              rready,
	output logic [15:0]            baudDivisor,
	output logic [6:0]             targetSupplyOut,
	output logic                   targetSupplyOn,
	output logic                   imgWrite,
	output logic [15:0]            imgAddr,
	output logic [7:0]             imgWdata,
	input  wire logic [7:0]        imgRdata,
	input  wire logic [7:0]        chanDetect,
	output logic                   stepReq,
	output logic [7:0]             stepCode,
	input  wire logic              stepDone,
	input  wire logic [7:0]        stepPass,
	output logic                   tgtReq,
	output gpe_tgt_kind_type       tgtKind,
	output logic [2:0]             tgtIndex,
	output logic [15:0]            tgtAddr,
	output logic [15:0]            tgtLen,
	output logic [15:0]            tgtWdata,
	output logic                   tgtByteAccess,
	output logic                   tgtWriteAll,
	output logic                   tgtSeriesBegin,
	output logic                   tgtSeriesEnd,
	input  wire logic              tgtDone,
	input  wire logic [15:0]       tgtRdata,
	output logic                   busy
);
	gpe_state_type state;
	logic [2:0]  baudIdx, stepIdx, accTarget, accFlags;
	logic [7:0]  flagsReg, supplyReg, modelReg, miscErr;
	logic [7:0]  resDetect, resCheck, resVerify, resFuse, resAll;
	logic [15:0] settleReg, timeoutReg, accAddr, accLen, accWdata, accRdata;
	logic [15:0] msCount, tenthCount;
	logic [31:0] chksumReg, rdMux, wrVal;
	logic        paramsValid, stepWait, checkPending, checkLast, mainEnd;
	logic        awHeld, wHeld, wrFire, cmdStart, timeoutHit, inMain;
	logic [ADDR_W-1:0] awAddrQ;
	logic [31:0] wDataQ;
	logic [3:0]  wStrbQ;
	logic [3:0]  cmdCode;
	gpe_tick_if  tick();

	function automatic logic reg_hit(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
		return a == ofs;
	endfunction

	function automatic logic [31:0] name_word(input logic [2:0] w);
		logic [31:0] v;
		int k;
		v = 32'h0;
		for (int b = 0; b < 4; b++)
		begin
			k = 4 * int'(w) + b;
			if (k < NAME_LEN - 1)
				v[8*b +: 8] = FW_NAME[8*(NAME_LEN-1-k) +: 8];
		end
		return v;
	endfunction

	gpe_tick_gen #(.CYCLES_PER_MS(CYCLES_PER_MS)) u_tick (
		.clk  (clk),
		.rst  (rst),
		.tick (tick)
	);

	assign awready = !awHeld;
	assign wready = !wHeld;
	assign arready = !rvalid;
	assign wrFire = awHeld && wHeld && !bvalid;
	assign busy = (state != ST_IDLE);
	assign cmdCode = wDataQ[3:0];
	assign cmdStart = wrFire && reg_hit(awAddrQ, OFS_CMD) && wStrbQ[0] && !busy;
	assign tick.restart = cmdStart;
	assign inMain = (state == ST_SETTLE) || (state == ST_STEP);
	// The abort comes one 100 ms unit early so the host hears back in time.
	assign timeoutHit = ({1'b0, tenthCount} + 17'h1) >= {1'b0, timeoutReg};
	assign imgWrite = (state == ST_FILL);
	assign imgWdata = ERASED_BYTE;
	assign tgtIndex = accTarget;
	assign tgtAddr = accAddr;
	assign tgtLen = accLen;
	assign tgtWdata = accWdata;

	always_comb
	begin
		wrVal = merge(32'h0, wDataQ, wStrbQ);
		unique case (awAddrQ)
			OFS_FLAGS:    wrVal = merge({24'h0, flagsReg}, wDataQ, wStrbQ);
			OFS_SUPPLY:   wrVal = merge({24'h0, supplyReg}, wDataQ, wStrbQ);
			OFS_SETTLE:   wrVal = merge({16'h0, settleReg}, wDataQ, wStrbQ);
			OFS_TIMEOUT:  wrVal = merge({16'h0, timeoutReg}, wDataQ, wStrbQ);
			OFS_MODEL:    wrVal = merge({24'h0, modelReg}, wDataQ, wStrbQ);
			OFS_CHKSUM:   wrVal = merge(chksumReg, wDataQ, wStrbQ);
			OFS_ACC_ADDR: wrVal = merge({accLen, accAddr}, wDataQ, wStrbQ);
			OFS_ACC_CTRL: wrVal = merge({21'h0, accFlags, 5'h0, accTarget}, wDataQ, wStrbQ);
			OFS_ACC_DATA: wrVal = merge({16'h0, accWdata}, wDataQ, wStrbQ);
			default:      wrVal = merge({29'h0, baudIdx}, wDataQ, wStrbQ);
		endcase
	end

	always_comb
	begin
		rdMux = 32'h0;
		unique case (araddr)
			OFS_BAUD:     rdMux = {baudDivisor, 13'h0, baudIdx};
			OFS_FLAGS:    rdMux = {24'h0, flagsReg};
			OFS_SUPPLY:   rdMux = {24'h0, supplyReg};
			OFS_SETTLE:   rdMux = {16'h0, settleReg};
			OFS_TIMEOUT:  rdMux = {16'h0, timeoutReg};
			OFS_CMD:      rdMux = {16'h0, miscErr, 6'h0, paramsValid, busy};
			OFS_MODEL:    rdMux = {24'h0, modelReg};
			OFS_CHKSUM:   rdMux = chksumReg;
			OFS_ACC_ADDR: rdMux = {accLen, accAddr};
			OFS_ACC_CTRL: rdMux = {21'h0, accFlags, 5'h0, accTarget};
			OFS_ACC_DATA: rdMux = {accRdata, accWdata};
			OFS_RES0:     rdMux = {resFuse, resVerify, resCheck, resDetect};
			OFS_RES1:     rdMux = {16'h0, miscErr, resAll};
			OFS_VER:      rdMux = {FW_VERSION[7:0], FW_VERSION[15:8],
				HW_VERSION[7:0], HW_VERSION[15:8]};
			default:
				if (araddr >= OFS_NAME && araddr < OFS_END && araddr[1:0] == 2'h0)
					rdMux = name_word(3'((araddr - OFS_NAME) >> 2));
		endcase
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			awHeld <= 1'b0;
			wHeld <= 1'b0;
			awAddrQ <= '0;
			wDataQ <= 32'h0;
			wStrbQ <= 4'h0;
			bvalid <= 1'b0;
			bresp <= RESP_OKAY;
			rvalid <= 1'b0;
			rdata <= 32'h0;
			rresp <= RESP_OKAY;
		end
		else
		begin
			if (awvalid && !awHeld)
			begin
				awHeld <= 1'b1;
				awAddrQ <= awaddr;
			end
			if (wvalid && !wHeld)
			begin
				wHeld <= 1'b1;
				wDataQ <= wdata;
				wStrbQ <= wstrb;
			end
			if (wrFire)
			begin
				awHeld <= 1'b0;
				wHeld <= 1'b0;
				bvalid <= 1'b1;
				bresp <= (awAddrQ < OFS_END && awAddrQ[1:0] == 2'h0) ? RESP_OKAY : RESP_SLVERR;
			end
			else if (bvalid && bready)
				bvalid <= 1'b0;
			if (arvalid && !rvalid)
			begin
				rvalid <= 1'b1;
				rdata <= rdMux;
				rresp <= (araddr < OFS_END && araddr[1:0] == 2'h0) ? RESP_OKAY : RESP_SLVERR;
			end
			else if (rvalid && rready)
				rvalid <= 1'b0;
		end
	end

	// Setup registers; single target fields are frozen while a command runs.
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			baudIdx <= BAUD_IDX_RESET;
			baudDivisor <= BAUD_DIV_RESET;
			flagsReg <= 8'h00;
			supplyReg <= 8'h00;
			settleReg <= 16'h0;
			timeoutReg <= 16'h0;
			modelReg <= 8'h00;
			chksumReg <= 32'h0;
			paramsValid <= 1'b0;
			accAddr <= 16'h0;
			accLen <= 16'h0;
			accTarget <= 3'h0;
			accFlags <= 3'h0;
			accWdata <= 16'h0;
		end
		else if (wrFire)
		begin
			if (reg_hit(awAddrQ, OFS_BAUD) && wrVal[2:0] <= BAUD_IDX_MAX)
			begin
				baudIdx <= wrVal[2:0];
				baudDivisor <= baud_div(wrVal[2:0]);
			end
			if (!busy)
			begin
				if (reg_hit(awAddrQ, OFS_FLAGS))
				begin
					flagsReg <= wrVal[7:0] & FLAG_MASK;
					paramsValid <= 1'b1;
				end
				if (reg_hit(awAddrQ, OFS_SUPPLY))
					supplyReg <= wrVal[7:0];
				if (reg_hit(awAddrQ, OFS_SETTLE))
					settleReg <= wrVal[15:0];
				if (reg_hit(awAddrQ, OFS_TIMEOUT))
					timeoutReg <= wrVal[15:0];
				if (reg_hit(awAddrQ, OFS_MODEL))
					modelReg <= wrVal[7:0];
				if (reg_hit(awAddrQ, OFS_CHKSUM))
					chksumReg <= wrVal;
				if (reg_hit(awAddrQ, OFS_ACC_ADDR))
					{accLen, accAddr} <= wrVal;
				if (reg_hit(awAddrQ, OFS_ACC_CTRL))
					{accFlags, accTarget} <= {wrVal[10:8], wrVal[2:0]};
				if (reg_hit(awAddrQ, OFS_ACC_DATA))
					accWdata <= wrVal[15:0];
			end
		end
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			state <= ST_IDLE;
			imgAddr <= IMG_FIRST;
			checkPending <= 1'b0;
			checkLast <= 1'b0;
			stepIdx <= 3'h0;
			stepWait <= 1'b0;
			stepReq <= 1'b0;
			stepCode <= 8'h00;
			msCount <= 16'h0;
			tenthCount <= 16'h0;
			mainEnd <= 1'b0;
			tgtReq <= 1'b0;
			tgtKind <= TGT_REG;
			tgtByteAccess <= 1'b0;
			tgtWriteAll <= 1'b0;
			tgtSeriesBegin <= 1'b0;
			tgtSeriesEnd <= 1'b0;
		end
		else
		begin
			stepReq <= 1'b0;
			tgtReq <= 1'b0;
			mainEnd <= 1'b0;
			if (tick.msTick && state == ST_SETTLE && msCount != 16'hffff)
				msCount <= msCount + 16'h1;
			if (tick.tenthTick && inMain && tenthCount != 16'hffff)
				tenthCount <= tenthCount + 16'h1;
			unique case (state)
				ST_IDLE:
					if (cmdStart)
					begin
						msCount <= 16'h0;
						tenthCount <= 16'h0;
						if (cmdCode == CMD_ERASE_IMAGE)
						begin
							state <= ST_FILL;
							imgAddr <= IMG_FIRST;
						end
						else if (cmdCode == CMD_MAIN && paramsValid)
							state <= ST_SETTLE;
						else if (cmdCode == CMD_REG_ACCESS || cmdCode == CMD_PROGRAM ||
							cmdCode == CMD_READ)
						begin
							state <= ST_TARGET;
							tgtReq <= 1'b1;
							tgtKind <= (cmdCode == CMD_REG_ACCESS) ? TGT_REG :
								(cmdCode == CMD_PROGRAM) ? TGT_PROGRAM : TGT_READ;
							tgtByteAccess <= accAddr < BYTE_ACCESS_LIMIT;
							tgtWriteAll <= accFlags[ACC_WRITE_BIT];
							tgtSeriesBegin <= accFlags[ACC_BEGIN_BIT];
							tgtSeriesEnd <= accFlags[ACC_END_BIT];
						end
					end
				ST_FILL:
					if (imgAddr == IMG_LAST)
					begin
						state <= ST_CHECK;
						imgAddr <= CHECK_FIRST;
						checkPending <= 1'b0;
						checkLast <= 1'b0;
					end
					else
						imgAddr <= imgAddr + 16'h1;
				ST_CHECK:
				begin
					// Read data lags the address by one cycle, so compares trail it.
					checkPending <= 1'b1;
					checkLast <= (imgAddr == IMG_LAST);
					if (imgAddr != IMG_LAST)
						imgAddr <= imgAddr + 16'h1;
					if (checkLast)
						state <= ST_IDLE;
				end
				ST_SETTLE:
					if (timeoutHit)
					begin
						state <= ST_IDLE;
						mainEnd <= 1'b1;
					end
					else if (msCount >= settleReg)
					begin
						state <= ST_STEP;
						stepIdx <= 3'h0;
						stepWait <= 1'b0;
					end
				ST_STEP:
					if (timeoutHit || (stepIdx == 3'(STEP_COUNT) && !stepWait))
					begin
						state <= ST_IDLE;
						mainEnd <= 1'b1;
						stepWait <= 1'b0;
					end
					else if (stepWait)
					begin
						if (stepDone)
						begin
							stepWait <= 1'b0;
							stepIdx <= stepIdx + 3'h1;
						end
					end
					else if ((flagsReg & step_bits(stepIdx)) == 8'h00)
						stepIdx <= stepIdx + 3'h1;
					else
					begin
						stepReq <= 1'b1;
						stepCode <= flagsReg & step_bits(stepIdx);
						stepWait <= 1'b1;
					end
				ST_TARGET:
					if (tgtDone)
						state <= ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			targetSupplyOn <= 1'b0;
			targetSupplyOut <= 7'h0;
		end
		else if (cmdStart && cmdCode == CMD_MAIN && paramsValid)
		begin
			targetSupplyOn <= 1'b1;
			targetSupplyOut <= 7'(supplyReg & SUPPLY_LEVEL_MASK);
		end
		else if (mainEnd && supplyReg[SUPPLY_OFF_BIT])
			targetSupplyOn <= 1'b0;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			{resDetect, resCheck, resVerify, resFuse, resAll} <= 40'h0;
			miscErr <= ERR_NONE;
			accRdata <= 16'h0;
		end
		else
		begin
			if (state == ST_TARGET && tgtDone)
				accRdata <= tgtRdata;
			if (cmdStart && cmdCode == CMD_MAIN)
			begin
				miscErr <= paramsValid ? ERR_NONE : ERR_NO_PARAMS;
				resDetect <= chanDetect;
				resAll <= chanDetect;
				{resCheck, resVerify, resFuse} <= 24'h0;
			end
			else if (cmdStart && cmdCode == CMD_ERASE_IMAGE)
				miscErr <= ERR_NONE;
			if (state == ST_CHECK && checkPending && imgRdata != ERASED_BYTE)
				miscErr <= ERR_IMAGE_ERASE;
			if (inMain && timeoutHit)
			begin
				miscErr <= ERR_TIMEOUT;
				resAll <= 8'h00;
			end
			else if (state == ST_STEP && stepWait && stepDone)
			begin
				resAll <= resAll & stepPass;
				if (stepCode == FLAG_CHECK)
					resCheck <= stepPass & resDetect;
				if (stepCode == FLAG_VERIFY)
					resVerify <= stepPass & resDetect;
				if (stepCode == FLAG_FUSE)
					resFuse <= stepPass & resDetect;
			end
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	a_baud_apply: assert property (wrFire && reg_hit(awAddrQ, OFS_BAUD) && !busy &&
		wrVal[2:0] <= BAUD_IDX_MAX |=> baudDivisor == baud_div($past(wrVal[2:0])))
		else $error("baud divisor not updated");
	a_fill_value: assert property (state == ST_FILL && imgAddr != IMG_LAST |-> imgWrite &&
		imgWdata == ERASED_BYTE ##1 state == ST_FILL && imgAddr == $past(imgAddr) + 16'h1)
		else $error("fill value wrong");
	a_fill_to_check: assert property (state == ST_FILL && imgAddr == IMG_LAST |=>
		state == ST_CHECK && imgAddr == CHECK_FIRST)
		else $error("check does not start at 0x1000");
	a_step_legal: assert property (stepReq |-> stepCode != 8'h00 &&
		(stepCode & ~FLAG_MASK) == 8'h00 && stepCode == (flagsReg & step_bits(stepIdx)))
		else $error("illegal step code");
	a_supply_off: assert property (mainEnd && supplyReg[SUPPLY_OFF_BIT] |=> !targetSupplyOn)
		else $error("supply left on");
	a_settle_wait: assert property ($past(state) == ST_SETTLE && state == ST_STEP |->
		$past(msCount) >= settleReg)
		else $error("settle time cut short");
	a_timeout_abort: assert property (inMain && timeoutHit |=>
		state == ST_IDLE && miscErr == ERR_TIMEOUT && mainEnd)
		else $error("timeout not honoured");
	a_result_mask: assert property (mainEnd |=> (resAll & ~resDetect) == 8'h00)
		else $error("pass mask outside detected");
	a_access_width: assert property (tgtReq && tgtKind == TGT_REG |->
		tgtByteAccess == (tgtAddr < BYTE_ACCESS_LIMIT))
		else $error("access width wrong");
	a_series_flags: assert property (tgtReq |-> tgtSeriesBegin == accFlags[ACC_BEGIN_BIT] &&
		tgtSeriesEnd == accFlags[ACC_END_BIT] && tgtWriteAll == accFlags[ACC_WRITE_BIT])
		else $error("access flags mis-decoded");
	c_erase_done: cover property (state == ST_CHECK && checkLast);
	c_main_done: cover property (mainEnd && miscErr == ERR_NONE);
	c_target_op: cover property (state == ST_TARGET && tgtDone);
endmodule

/* hdl/gpe_pkg.sv */
package gpe_pkg;
	localparam int CLK_HZ = 125_000_000;
	localparam int MS_PER_S = 1000;
	localparam int TENTH_MS = 100;
	localparam int ADDR_W = 8;
	localparam int NAME_LEN = 18;
	localparam int NAME_WORDS = 5;
	localparam int STEP_COUNT = 5;

	localparam int BAUD_RATE [5] = '{9600, 19200, 38400, 57600, 115200};
	localparam logic [2:0] BAUD_IDX_MAX = 3'h4;
	localparam logic [2:0] BAUD_IDX_RESET = 3'h4;
	localparam logic [15:0] BAUD_DIV_RESET = 16'(CLK_HZ / 115200);

	localparam logic [7:0] OFS_BAUD = 8'h00;
	localparam logic [7:0] OFS_FLAGS = 8'h04;
	localparam logic [7:0] OFS_SUPPLY = 8'h08;
	localparam logic [7:0] OFS_SETTLE = 8'h0c;
	localparam logic [7:0] OFS_TIMEOUT = 8'h10;
	localparam logic [7:0] OFS_CMD = 8'h14;
	localparam logic [7:0] OFS_MODEL = 8'h18;
	localparam logic [7:0] OFS_CHKSUM = 8'h1c;
	localparam logic [7:0] OFS_ACC_ADDR = 8'h20;
	localparam logic [7:0] OFS_ACC_CTRL = 8'h24;
	localparam logic [7:0] OFS_ACC_DATA = 8'h28;
	localparam logic [7:0] OFS_RES0 = 8'h2c;
	localparam logic [7:0] OFS_RES1 = 8'h30;
	localparam logic [7:0] OFS_VER = 8'h34;
	localparam logic [7:0] OFS_NAME = 8'h38;
	localparam logic [7:0] OFS_END = 8'h4c;

	localparam logic [7:0] FLAG_ERASE = 8'h03;
	localparam logic [7:0] FLAG_PROGRAM = 8'h0c;
	localparam logic [7:0] FLAG_CHECK = 8'h10;
	localparam logic [7:0] FLAG_VERIFY = 8'h20;
	localparam logic [7:0] FLAG_FUSE = 8'h40;
	localparam logic [7:0] FLAG_MASK = 8'h7f;
	localparam logic [7:0] SUPPLY_LEVEL_MASK = 8'h7f;
	localparam int SUPPLY_OFF_BIT = 7;

	localparam logic [15:0] IMG_FIRST = 16'h0000;
	localparam logic [15:0] IMG_LAST = 16'hffff;
	localparam logic [15:0] CHECK_FIRST = 16'h1000;
	localparam logic [7:0] ERASED_BYTE = 8'hff;
	localparam logic [15:0] BYTE_ACCESS_LIMIT = 16'h0100;
	localparam int ACC_WRITE_BIT = 0;
	localparam int ACC_BEGIN_BIT = 1;
	localparam int ACC_END_BIT = 2;

	localparam logic [3:0] CMD_ERASE_IMAGE = 4'h1;
	localparam logic [3:0] CMD_MAIN = 4'h2;
	localparam logic [3:0] CMD_REG_ACCESS = 4'h3;
	localparam logic [3:0] CMD_PROGRAM = 4'h4;
	localparam logic [3:0] CMD_READ = 4'h5;

	localparam logic [7:0] ERR_NONE = 8'h00;
	localparam logic [7:0] ERR_TIMEOUT = 8'h01;
	localparam logic [7:0] ERR_IMAGE_ERASE = 8'h02;
	localparam logic [7:0] ERR_NO_PARAMS = 8'h03;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {TGT_REG = 2'h0, TGT_PROGRAM = 2'h1, TGT_READ = 2'h2} gpe_tgt_kind_type;

	typedef enum logic [5:0] {
		ST_IDLE   = 6'h01,
		ST_FILL   = 6'h02,
		ST_CHECK  = 6'h04,
		ST_SETTLE = 6'h08,
		ST_STEP   = 6'h10,
		ST_TARGET = 6'h20
	} gpe_state_type;

	function automatic logic [15:0] baud_div(input logic [2:0] idx);
		return 16'(CLK_HZ / BAUD_RATE[int'(idx)]);
	endfunction

	function automatic logic [7:0] step_bits(input logic [2:0] idx);
		logic [7:0] s;
		unique case (idx)
			3'h0: s = FLAG_ERASE;
			3'h1: s = FLAG_CHECK;
			3'h2: s = FLAG_PROGRAM;
			3'h3: s = FLAG_VERIFY;
			3'h4: s = FLAG_FUSE;
			default: s = 8'h00;
		endcase
		return s;
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] v;
		v = old;
		for (int b = 0; b < 4; b++)
			if (strb[b])
				v[8*b +: 8] = nw[8*b +: 8];
		return v;
	endfunction
endpackage

/* hdl/gpe_tick_if.sv */
`timescale 1ns/1ns
interface gpe_tick_if;
	logic restart;
	logic msTick;
	logic tenthTick;
	modport gen (input restart, output msTick, output tenthTick);
	modport user (output restart, input msTick, input tenthTick);
endinterface

/* hdl/gpe_tick_gen.sv */
`timescale 1ns/1ns
module gpe_tick_gen
	import gpe_pkg::*;
#(
	parameter int CYCLES_PER_MS = CLK_HZ / MS_PER_S
)(
	input  wire logic clk,
	input  wire logic rst,
	gpe_tick_if.gen   tick
);
	logic [31:0] cycCount;
	logic [7:0]  msCount;

	// A restart realigns both ticks so a wait starts on a whole millisecond.
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			cycCount <= 32'h0;
			msCount <= 8'h0;
			tick.msTick <= 1'b0;
			tick.tenthTick <= 1'b0;
		end
		else if (tick.restart)
		begin
			cycCount <= 32'h0;
			msCount <= 8'h0;
			tick.msTick <= 1'b0;
			tick.tenthTick <= 1'b0;
		end
		else
		begin
			tick.msTick <= (cycCount == 32'(CYCLES_PER_MS - 1));
			tick.tenthTick <= (cycCount == 32'(CYCLES_PER_MS - 1)) &&
				(msCount == 8'(TENTH_MS - 1));
			if (cycCount == 32'(CYCLES_PER_MS - 1))
			begin
				cycCount <= 32'h0;
				msCount <= (msCount == 8'(TENTH_MS - 1)) ? 8'h0 : msCount + 8'h1;
			end
			else
				cycCount <= cycCount + 32'h1;
		end
	end
endmodule

/* tb/gpe_far_model.sv */
`timescale 1ns/1ns
module gpe_far_model (
	input  wire logic        clk,
	input  wire logic        imgWrite,
	input  wire logic [15:0] imgAddr,
	input  wire logic [7:0]  imgWdata,
	output logic      [7:0]  imgRdata,
	input  wire logic        stepReq,
	output logic             stepDone,
	output logic      [7:0]  stepPass,
	input  wire logic        tgtReq,
	input  wire logic [15:0] tgtAddr,
	output logic             tgtDone,
	output logic      [15:0] tgtRdata
);
	logic [7:0] mem [65536];
	int         stepWait = 0;
	int         tgtWait = 0;
	// Steps answer slowly, targets promptly; result lines show junk when not qualified.
	assign stepPass = stepDone ? 8'h07 : 8'ha8;
	assign tgtRdata = tgtDone ? tgtAddr ^ 16'ha5a5 : 16'h5a5a;
	initial stepDone = 1'b0;
	initial tgtDone = 1'b0;
	always @(posedge clk)
	begin
		if (imgWrite)
			mem[imgAddr] <= imgWdata;
		imgRdata <= mem[imgAddr];
		stepWait <= stepReq ? 9 : (stepWait > 0 ? stepWait - 1 : 0);
		stepDone <= stepWait == 1;
		tgtWait <= tgtReq ? 2 : (tgtWait > 0 ? tgtWait - 1 : 0);
		tgtDone <= tgtWait == 1;
	end
endmodule

/* tb/gang_programmer_command_engine_bench.sv */
`timescale 1ns/1ns
module gang_programmer_command_engine_bench import gpe_pkg::*;;
	logic             clk = 1'b0, rst = 1'b1, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic             arvalid = 1'b0, rready = 1'b0;
	logic [7:0]       awaddr = 8'h00, araddr = 8'h00, chanDetect = 8'h0f;
	logic [31:0]      wdata = 32'h0, rdata, d;
	logic [3:0]       wstrb = 4'hf;
	logic [1:0]       bresp, rresp, r;
	logic             awready, wready, bvalid, arready, rvalid, imgWrite, stepReq, stepDone;
	logic             tgtReq, tgtDone, tgtByteAccess, tgtWriteAll, tgtSeriesBegin, tgtSeriesEnd;
	logic             busy, targetSupplyOn;
	logic [15:0]      baudDivisor, imgAddr, tgtAddr, tgtLen, tgtWdata, tgtRdata;
	logic [7:0]       imgRdata, imgWdata, stepCode, stepPass;
	logic [6:0]       targetSupplyOut;
	logic [2:0]       tgtIndex;
	gpe_tgt_kind_type tgtKind;
	logic [7:0]       codes [$];
	logic [23:0]      tgtSnap;
	logic [15:0]      ta [4] = '{16'h0100, 16'h00ff, 16'h1000, 16'hf000};
	logic [2:0]       tf [4] = '{3'h3, 3'h4, 3'h0, 3'h0};
	logic [2:0]       ti [4] = '{3'h7, 3'h0, 3'h3, 3'h0};
	logic [3:0]       tc [4] = '{CMD_REG_ACCESS, CMD_REG_ACCESS, CMD_PROGRAM, CMD_READ};
	gpe_tgt_kind_type tk [4] = '{TGT_REG, TGT_REG, TGT_PROGRAM, TGT_READ};
	int               error_cnt = 0, tests_run = 0, cyc = 0, tCmd = 0, tStep = 0;

	gpe_engine #(.CYCLES_PER_MS(10), .HW_VERSION(16'h1234), .FW_VERSION(16'h5678)) dut (
		.clk, .rst, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp,
		.bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
		.baudDivisor, .targetSupplyOut, .targetSupplyOn, .imgWrite, .imgAddr, .imgWdata,
		.imgRdata, .chanDetect, .stepReq, .stepCode, .stepDone, .stepPass, .tgtReq, .tgtKind,
		.tgtIndex, .tgtAddr, .tgtLen, .tgtWdata, .tgtByteAccess, .tgtWriteAll,
		.tgtSeriesBegin, .tgtSeriesEnd, .tgtDone, .tgtRdata, .busy);
	gpe_far_model far (.clk, .imgWrite, .imgAddr, .imgWdata, .imgRdata, .stepReq, .stepDone,
		.stepPass, .tgtReq, .tgtAddr, .tgtDone, .tgtRdata);

	always #4 clk = ~clk;
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (stepReq === 1'b1 && codes.size() == 0)
			tStep <= cyc;
		if (stepReq === 1'b1)
			codes.push_back(stepCode);
		if (tgtReq === 1'b1)
			tgtSnap <= {tgtKind, tgtIndex, tgtSeriesEnd, tgtSeriesBegin, tgtWriteAll, tgtAddr};
		if (cyc == 20000)
		begin
			error_cnt++;
			summarize();
		end
	end

	task automatic summarize();
		$display("checks %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e)
		begin
			error_cnt++;
			$display("unexpected at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	// Both channels are offered together; the response handshake ends the access.
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		logic aw = 1'b0, w = 1'b0;
		awaddr <= a; wdata <= v; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
		forever
		begin
			@(posedge clk);
			if (aw && w && bvalid === 1'b1)
				break;
			if (awready === 1'b1)
			begin
				aw = 1'b1;
				awvalid <= 1'b0;
			end
			if (wready === 1'b1)
			begin
				w = 1'b1;
				wvalid <= 1'b0;
			end
		end
		bready <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rd(input logic [7:0] a);
		logic ar = 1'b0;
		araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
		forever
		begin
			@(posedge clk);
			if (ar && rvalid === 1'b1)
				break;
			if (arready === 1'b1)
			begin
				ar = 1'b1;
				arvalid <= 1'b0;
			end
		end
		{d, r} = {rdata, rresp};
		rready <= 1'b0;
		@(posedge clk);
	endtask
	task automatic waitIdle();
		while (busy !== 1'b0)
			@(posedge clk);
		// Outputs that follow the return to idle settle one edge later.
		@(posedge clk);
	endtask

	initial
	begin
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rd(OFS_BAUD); chk(d, {16'(CLK_HZ / 115200), 16'h0004});
		for (int i = 0; i < 6; i++)
		begin
			wr(OFS_BAUD, 32'(i));
			chk(32'(baudDivisor), 32'(CLK_HZ / BAUD_RATE[i > 4 ? 4 : i]));
		end
		$display("test done: baud");
		wr(OFS_CMD, 32'(CMD_MAIN)); waitIdle(); rd(OFS_CMD);
		chk(d & 32'hff03, {16'h0, ERR_NO_PARAMS, 8'h00});
		wr(OFS_FLAGS, 32'hb5); rd(OFS_FLAGS); chk(d, 32'h35);
		wr(OFS_SUPPLY, 32'h9e); wr(OFS_SETTLE, 32'h2); wr(OFS_TIMEOUT, 32'h64);
		tCmd = cyc;
		wr(OFS_CMD, 32'(CMD_MAIN));
		chk({targetSupplyOn, 24'h0, targetSupplyOut}, 32'h8000001e);
		waitIdle();
		chk(32'((tStep - tCmd) inside {[20:40]}), 32'h1);
		chk(32'(codes.size()), 32'h4);
		chk({codes[0], codes[1], codes[2], codes[3]}, 32'h01100420);
		chk(32'(targetSupplyOn), 32'h0);
		rd(OFS_RES0); chk(d & 32'hffffff, 32'h07070f);
		rd(OFS_RES1); chk(d, 32'h7);
		wr(OFS_TIMEOUT, 32'h1); wr(OFS_CMD, 32'(CMD_MAIN)); waitIdle();
		rd(OFS_CMD); chk(d & 32'hff00, {16'h0, ERR_TIMEOUT, 8'h00});
		$display("test done: main process");
		rd(OFS_VER); chk(d, 32'h78563412);
		rd(OFS_NAME); chk(d, 32'h4d524946);
		rd(OFS_NAME + 8'h10); chk(d, 32'h0);
		rd(OFS_END); chk({r, d[29:0]}, {RESP_SLVERR, 30'h0});
		wr(OFS_CHKSUM, 32'hbeef1234); rd(OFS_CHKSUM); chk(d, 32'hbeef1234);
		wr(OFS_MODEL, 32'ha3); rd(OFS_MODEL); chk(d, 32'ha3);
		$display("test done: result record");
		for (int i = 0; i < 4; i++)
		begin
			wr(OFS_ACC_ADDR, {16'h0002, ta[i]});
			wr(OFS_ACC_CTRL, {21'h0, tf[i], 5'h00, ti[i]});
			wr(OFS_CMD, {28'h0, tc[i]}); waitIdle();
			chk(32'(tgtSnap), 32'({tk[i], ti[i], tf[i], ta[i]}));
			chk({16'h0, tgtByteAccess, 15'h0}, {16'h0, ta[i] < 16'h0100, 15'h0});
			rd(OFS_ACC_DATA); chk({d[31:16], 16'h0}, {ta[i] ^ 16'ha5a5, 16'h0});
			chk({tgtLen, tgtWdata}, {16'h0002, 16'h0000});
		end
		$display("test done: single target");
		// The full fill and check runs far past the cycle budget, so only its start is seen.
		wr(OFS_CMD, 32'(CMD_ERASE_IMAGE));
		repeat (100) @(posedge clk);
		chk({imgWrite, 15'h0, imgWdata, 8'h00}, 32'h8000ff00);
		rst <= 1'b1;
		@(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		chk({busy, imgWrite, 14'h0, baudDivisor}, {16'h0, 16'(CLK_HZ / 115200)});
		$display("test done: image erase");
		summarize();
	end
endmodule
